// [verilog/video_prescaler_pkg.sv]
// Register map, field layout, reset values and arithmetic constants of the video prescaler front end
package video_prescaler_pkg;
  // Register set A
  localparam logic [7:0] seta_prescale_accum_length = 8'ha1;
  localparam logic [7:0] seta_prefilter_and_gain = 8'ha2;
  localparam logic [7:0] seta_luma_brightness = 8'ha4;
  localparam logic [7:0] seta_luma_contrast = 8'ha5;
  localparam logic [7:0] seta_chroma_saturation = 8'ha6;
  localparam logic [7:0] seta_hluma_increment_low = 8'ha8;
  localparam logic [7:0] seta_hluma_increment_high = 8'ha9;
  // Register set B
  localparam logic [7:0] setb_prescale_accum_length = 8'hd1;
  localparam logic [7:0] setb_prefilter_and_gain = 8'hd2;
  localparam logic [7:0] setb_luma_brightness = 8'hd4;
  localparam logic [7:0] setb_luma_contrast = 8'hd5;
  localparam logic [7:0] setb_chroma_saturation = 8'hd6;
  localparam logic [7:0] setb_hluma_increment_low = 8'hd8;
  localparam logic [7:0] setb_hluma_increment_high = 8'hd9;
  // Read-only block state
  localparam logic [7:0] block_status = 8'hf0;

  // Storage slots within one set
  localparam logic [2:0] slot_accum = 3'h0;
  localparam logic [2:0] slot_filter_gain = 3'h1;
  localparam logic [2:0] slot_brightness = 3'h2;
  localparam logic [2:0] slot_contrast = 3'h3;
  localparam logic [2:0] slot_saturation = 3'h4;
  localparam logic [2:0] slot_inc_low = 3'h5;
  localparam logic [2:0] slot_inc_high = 3'h6;
  localparam int unsigned slot_count = 7;

  // Field positions and writable masks
  localparam int unsigned dc_gain_lsb = 0;
  localparam int unsigned weighting_bit = 3;
  localparam int unsigned luma_prefilter_lsb = 4;
  localparam int unsigned chroma_prefilter_lsb = 6;
  localparam logic [7:0] accum_length_mask = 8'h3f;
  localparam logic [7:0] inc_high_mask = 8'h1f;

  // Reset values: neutral picture, unity scale
  localparam logic [7:0] reset_accum = 8'h00;
  localparam logic [7:0] reset_filter_gain = 8'h00;
  localparam logic [7:0] reset_brightness = 8'h80;
  localparam logic [7:0] reset_contrast = 8'h40;
  localparam logic [7:0] reset_saturation = 8'h40;
  localparam logic [7:0] reset_inc_low = 8'h00;
  localparam logic [7:0] reset_inc_high = 8'h04;

  // Arithmetic
  localparam int unsigned fir_shift = 5;
  localparam int unsigned gain_shift = 6;
  localparam int unsigned phase_bits = 10;
  localparam logic [15:0] phase_one = 16'h0400;
  localparam logic signed [19:0] sample_mid = 20'sh00080;
  localparam int unsigned fifo_depth = 8;
endpackage

// [verilog/video_prescaler_bcs_hscale.sv]
// Sample FIFO and the prescaler, prefilter, brightness/contrast/saturation and horizontal scaler
`timescale 1ns/1ns

module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  input wire logic out_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic load;

  // Output word is a register so the drain side sees flop outputs
  assign in_ready = (count != CW'(DEPTH));
  assign push = in_valid && in_ready;
  assign load = (count != '0) && (!out_valid || out_ready);

  // Storage
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (load) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + CW'(push) - CW'(load);
    end
  end

  // Head register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// What this block does
// - The accumulation length field n sums a sequence of n+1 samples, 1 to 64.
// - The luma prefilter select picks bypass, (1 2 1)/4, the seven-tap (-1 1 1.75 4.5 1.75 1 -1)/8 or (1 2 2 2 1)/8.
// - The chroma prefilter select picks bypass, (1 2 1)/4, (3 8 10 8 3)/32 or (1 2 2 2 1)/8.
// - The DC gain field n divides the accumulated sum by 2 to the n, from 1 down to 1/128.
// - With the weighting bit clear every sample of a sequence counts once.
// - With the weighting bit set inner samples count twice and the two end samples once.
// - Brightness is an unsigned 8-bit offset with 128 as neutral.
// - Luma is multiplied by contrast/64, unity at 64, at most 127/64.
// - Chroma is multiplied by saturation/64 about its zero level, unity at 64, at most 127/64.
// - Luma is resampled horizontally by 1024/increment, so 1024 is unity.
// - The top three increment bits are held at zero, leaving 8191 as the largest value.
// - Every setting exists in set A and set B at separate addresses.
module video_prescaler_bcs_hscale (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Set select from acquisition logic
  input wire logic set_b_select,
  // Input samples
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_luma,
  input wire logic [7:0] in_chroma,
  // Output samples
  input wire logic out_ready,
  output logic out_valid,
  output logic [7:0] out_luma,
  output logic [7:0] out_chroma
);
  logic [7:0] cfg [0:1][0:video_prescaler_pkg::slot_count-1];
  logic [4:0] dec;
  logic act;
  logic [5:0] accum_len;
  logic [7:0] fg;
  logic [7:0] bright, contrast, saturation;
  logic [15:0] inc;
  logic hold_valid;
  logic next_hold_valid;
  logic [7:0] hold_luma, hold_chroma;
  logic step;
  logic [6:0][7:0] luma_win, chroma_win;
  logic [7:0] filt_luma, filt_chroma;
  logic [5:0] seq_pos;
  logic seq_last;
  logic [15:0] acc_luma, acc_chroma;
  logic [15:0] sum_luma, sum_chroma;
  logic [7:0] pres_luma, pres_chroma;
  logic bcs_valid;
  logic [7:0] bcs_luma, bcs_chroma;
  logic [1:0] primed;
  logic [15:0] phase;
  logic [7:0] prev_luma, cur_luma, prev_chroma, cur_chroma;
  logic need_sample;
  logic scaler_take;
  logic emit;
  logic fifo_in_ready;
  logic [15:0] fifo_out_data;

  // Saturate a signed intermediate to an 8-bit sample
  function automatic logic [7:0] clip8(input logic signed [19:0] v);
    if (v < 20'sh00000) begin
      clip8 = 8'h00;
    end else if (v > 20'sh000ff) begin
      clip8 = 8'hff;
    end else begin
      clip8 = v[7:0];
    end
  endfunction

  // Symmetric prefilter on a seven-sample window, weights in 1/32 units
  function automatic logic [7:0] fir(input logic [1:0] sel, input logic [6:0][7:0] w, input logic chroma);
    logic signed [19:0] x [0:6];
    logic signed [19:0] acc;
    for (int i = 0; i < 7; i++) begin
      x[i] = $signed({12'h000, w[i]});
    end
    unique case (sel)
      2'h0: acc = x[3] <<< video_prescaler_pkg::fir_shift;
      2'h1: acc = 20'sh8 * x[2] + 20'sh10 * x[3] + 20'sh8 * x[4];
      2'h2: begin
        if (chroma) begin
          acc = 20'sh3 * (x[1] + x[5]) + 20'sh8 * (x[2] + x[4]) + 20'sha * x[3];
        end else begin
          acc = 20'sh4 * (x[1] + x[5] - x[0] - x[6]) + 20'sh7 * (x[2] + x[4]) + 20'sh12 * x[3];
        end
      end
      2'h3: acc = 20'sh4 * (x[1] + x[5]) + 20'sh8 * (x[2] + x[3] + x[4]);
    endcase
    fir = clip8(acc >>> video_prescaler_pkg::fir_shift);
  endfunction

  // Linear interpolation between two samples at a 10-bit fraction
  function automatic logic [7:0] lerp(input logic [7:0] a, input logic [7:0] b, input logic [9:0] frac);
    logic signed [19:0] d;
    d = $signed({12'h000, b}) - $signed({12'h000, a});
    lerp = clip8($signed({12'h000, a}) + ((d * $signed({10'h000, frac})) >>> video_prescaler_pkg::phase_bits));
  endfunction

  // Address to {hit, set, slot}
  function automatic logic [4:0] decode(input logic [7:0] a);
    unique case (a)
      video_prescaler_pkg::seta_prescale_accum_length: decode = {2'b10, video_prescaler_pkg::slot_accum};
      video_prescaler_pkg::seta_prefilter_and_gain: decode = {2'b10, video_prescaler_pkg::slot_filter_gain};
      video_prescaler_pkg::seta_luma_brightness: decode = {2'b10, video_prescaler_pkg::slot_brightness};
      video_prescaler_pkg::seta_luma_contrast: decode = {2'b10, video_prescaler_pkg::slot_contrast};
      video_prescaler_pkg::seta_chroma_saturation: decode = {2'b10, video_prescaler_pkg::slot_saturation};
      video_prescaler_pkg::seta_hluma_increment_low: decode = {2'b10, video_prescaler_pkg::slot_inc_low};
      video_prescaler_pkg::seta_hluma_increment_high: decode = {2'b10, video_prescaler_pkg::slot_inc_high};
      video_prescaler_pkg::setb_prescale_accum_length: decode = {2'b11, video_prescaler_pkg::slot_accum};
      video_prescaler_pkg::setb_prefilter_and_gain: decode = {2'b11, video_prescaler_pkg::slot_filter_gain};
      video_prescaler_pkg::setb_luma_brightness: decode = {2'b11, video_prescaler_pkg::slot_brightness};
      video_prescaler_pkg::setb_luma_contrast: decode = {2'b11, video_prescaler_pkg::slot_contrast};
      video_prescaler_pkg::setb_chroma_saturation: decode = {2'b11, video_prescaler_pkg::slot_saturation};
      video_prescaler_pkg::setb_hluma_increment_low: decode = {2'b11, video_prescaler_pkg::slot_inc_low};
      video_prescaler_pkg::setb_hluma_increment_high: decode = {2'b11, video_prescaler_pkg::slot_inc_high};
      default: decode = 5'h00;
    endcase
  endfunction

  // Reset value of each slot
  function automatic logic [7:0] slot_reset(input int unsigned s);
    unique case (s)
      0: slot_reset = video_prescaler_pkg::reset_accum;
      1: slot_reset = video_prescaler_pkg::reset_filter_gain;
      2: slot_reset = video_prescaler_pkg::reset_brightness;
      3: slot_reset = video_prescaler_pkg::reset_contrast;
      4: slot_reset = video_prescaler_pkg::reset_saturation;
      5: slot_reset = video_prescaler_pkg::reset_inc_low;
      default: slot_reset = video_prescaler_pkg::reset_inc_high;
    endcase
  endfunction

  // Unused bits of the accumulation length and increment high slots are never stored, so they read back as zero
  function automatic logic [7:0] slot_mask(input logic [2:0] s);
    if (s == video_prescaler_pkg::slot_accum) begin
      slot_mask = video_prescaler_pkg::accum_length_mask;
    end else if (s == video_prescaler_pkg::slot_inc_high) begin
      slot_mask = video_prescaler_pkg::inc_high_mask;
    end else begin
      slot_mask = 8'hff;
    end
  endfunction

  assign dec = decode(reg_addr);

  // Two register sets, written by address
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < 2; s++) begin
        for (int f = 0; f < video_prescaler_pkg::slot_count; f++) begin
          cfg[s][f] <= slot_reset(f);
        end
      end
    end else if (reg_write && dec[4]) begin
      cfg[dec[3]][dec[2:0]] <= reg_wdata & slot_mask(dec[2:0]);
    end
  end

  // Read data stand for exactly one cycle after the read strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read && dec[4]) begin
      reg_rdata <= cfg[dec[3]][dec[2:0]];
    end else if (reg_read && reg_addr == video_prescaler_pkg::block_status) begin
      reg_rdata <= {4'h0, bcs_valid, out_valid, hold_valid, set_b_select};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Active set: switching mid-line takes effect on the next sample
  assign act = set_b_select;
  assign accum_len = cfg[act][video_prescaler_pkg::slot_accum][5:0];
  assign fg = cfg[act][video_prescaler_pkg::slot_filter_gain];
  assign bright = cfg[act][video_prescaler_pkg::slot_brightness];
  assign contrast = cfg[act][video_prescaler_pkg::slot_contrast];
  assign saturation = cfg[act][video_prescaler_pkg::slot_saturation];
  assign inc = {3'h0, cfg[act][video_prescaler_pkg::slot_inc_high][4:0],
                cfg[act][video_prescaler_pkg::slot_inc_low]};

  // Input holding register; half rate is ample for the pixel rate
  assign next_hold_valid = (hold_valid && !step) || (in_valid && in_ready);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_valid <= 1'b0;
      in_ready <= 1'b1;
      hold_luma <= 8'h00;
      hold_chroma <= 8'h00;
    end else begin
      hold_valid <= next_hold_valid;
      in_ready <= !next_hold_valid;
      if (in_valid && in_ready) begin
        hold_luma <= in_luma;
        hold_chroma <= in_chroma;
      end
    end
  end

  // Front end advances one sample per step; a waiting result blocks it
  assign step = hold_valid && !(bcs_valid && !scaler_take);

  // Prefilter windows and filtered samples
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      luma_win <= '0;
      chroma_win <= '0;
      filt_luma <= 8'h00;
      filt_chroma <= 8'h00;
    end else if (step) begin
      luma_win <= {luma_win[5:0], hold_luma};
      chroma_win <= {chroma_win[5:0], hold_chroma};
      filt_luma <= fir(fg[video_prescaler_pkg::luma_prefilter_lsb +: 2], luma_win, 1'b0);
      filt_chroma <= fir(fg[video_prescaler_pkg::chroma_prefilter_lsb +: 2], chroma_win, 1'b1);
    end
  end

  // Weighted sums including the current sample
  always_comb begin
    seq_last = (seq_pos >= accum_len);
    if (fg[video_prescaler_pkg::weighting_bit] && seq_pos != 6'h00 && !seq_last) begin
      sum_luma = acc_luma + {7'h00, filt_luma, 1'b0};
      sum_chroma = acc_chroma + {7'h00, filt_chroma, 1'b0};
    end else begin
      sum_luma = acc_luma + {8'h00, filt_luma};
      sum_chroma = acc_chroma + {8'h00, filt_chroma};
    end
    pres_luma = clip8($signed({4'h0, sum_luma >> fg[video_prescaler_pkg::dc_gain_lsb +: 3]}));
    pres_chroma = clip8($signed({4'h0, sum_chroma >> fg[video_prescaler_pkg::dc_gain_lsb +: 3]}));
  end

  // Accumulation sequence
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seq_pos <= 6'h00;
      acc_luma <= 16'h0000;
      acc_chroma <= 16'h0000;
    end else if (step) begin
      if (seq_last) begin
        seq_pos <= 6'h00;
        acc_luma <= 16'h0000;
        acc_chroma <= 16'h0000;
      end else begin
        seq_pos <= seq_pos + 6'h01;
        acc_luma <= sum_luma;
        acc_chroma <= sum_chroma;
      end
    end
  end

  // Brightness, contrast and saturation on each prescaled sample
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bcs_valid <= 1'b0;
      bcs_luma <= 8'h00;
      bcs_chroma <= 8'h00;
    end else if (step && seq_last) begin
      bcs_valid <= 1'b1;
      bcs_luma <= clip8((($signed({12'h000, pres_luma}) * $signed({13'h0000, contrast[6:0]}))
                          >>> video_prescaler_pkg::gain_shift)
                        + $signed({12'h000, bright}) - video_prescaler_pkg::sample_mid);
      bcs_chroma <= clip8(((($signed({12'h000, pres_chroma}) - video_prescaler_pkg::sample_mid)
                            * $signed({13'h0000, saturation[6:0]})) >>> video_prescaler_pkg::gain_shift)
                          + video_prescaler_pkg::sample_mid);
    end else if (scaler_take) begin
      bcs_valid <= 1'b0;
    end
  end

  // Resampler: phase below one means an output lies between prev and cur
  assign need_sample = (primed != 2'h2) || (phase >= video_prescaler_pkg::phase_one);
  assign scaler_take = bcs_valid && need_sample;
  assign emit = !need_sample && fifo_in_ready;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      primed <= 2'h0;
      phase <= 16'h0000;
      prev_luma <= 8'h00;
      cur_luma <= 8'h00;
      prev_chroma <= 8'h00;
      cur_chroma <= 8'h00;
    end else if (scaler_take) begin
      prev_luma <= cur_luma;
      cur_luma <= bcs_luma;
      prev_chroma <= cur_chroma;
      cur_chroma <= bcs_chroma;
      if (primed != 2'h2) begin
        primed <= primed + 2'h1;
      end else begin
        phase <= phase - video_prescaler_pkg::phase_one;
      end
    end else if (emit) begin
      phase <= phase + inc;
    end
  end

  // Output buffer absorbs bursts when zooming
  sample_fifo #(
    .WIDTH(16),
    .DEPTH(video_prescaler_pkg::fifo_depth)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(emit),
    .in_ready(fifo_in_ready),
    .in_data({lerp(prev_luma, cur_luma, phase[9:0]), lerp(prev_chroma, cur_chroma, phase[9:0])}),
    .out_ready(out_ready),
    .out_valid(out_valid),
    .out_data(fifo_out_data)
  );

  assign out_luma = fifo_out_data[15:8];
  assign out_chroma = fifo_out_data[7:0];
endmodule

// [sim/video_prescaler_bcs_hscale_properties.sv]
// Port checker for the register port and sample streams of the video prescaler
`timescale 1ns/1ns
module prescaler_port_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Sample streams
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_ready,
  input wire logic out_valid,
  input wire logic [7:0] out_luma,
  input wire logic [7:0] out_chroma
);
  logic [7:0] shadow [0:255];
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Neutral picture and unity scale after reset
  function automatic logic [7:0] start_value(input logic [3:0] lo);
    return lo == 4'h4 ? 8'h80 : (lo == 4'h5 || lo == 4'h6) ? 8'h40 : lo == 4'h9 ? 8'h04 : 8'h00;
  endfunction
  // Reserved bits never stick
  function automatic logic [7:0] keep(input logic [3:0] lo);
    return lo == 4'h1 ? 8'h3f : lo == 4'h9 ? 8'h1f : 8'hff;
  endfunction
  // Shadow of every byte the bus wrote
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 256; i++) begin
        shadow[i] <= start_value(i[3:0]);
      end
    end else if (reg_write) begin
      shadow[reg_addr] <= reg_wdata & keep(reg_addr[3:0]);
    end
  end
  // A read of slot lo in either set returns what was last stored there
  property read_back(logic [3:0] lo);
    reg_read && (reg_addr == {4'ha, lo} || reg_addr == {4'hd, lo}) |=> reg_rdata == shadow[$past(reg_addr)];
  endproperty
  a_accum_readback: assert property (read_back(4'h1)) else $error("accumulation length read wrong");
  a_filter_readback: assert property (read_back(4'h2)) else $error("prefilter and gain read wrong");
  a_bright_readback: assert property (read_back(4'h4)) else $error("brightness read wrong");
  a_contrast_readback: assert property (read_back(4'h5)) else $error("contrast read wrong");
  a_satur_readback: assert property (read_back(4'h6)) else $error("saturation read wrong");
  a_inc_low_readback: assert property (read_back(4'h8)) else $error("increment low read wrong");
  a_inc_high_reserved: assert property (read_back(4'h9)) else $error("increment high read wrong");
  a_unmapped_zero: assert property (reg_read && reg_addr == 8'ha3 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00) else $error("read data outside its cycle");
  a_out_stall_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_luma) && $stable(out_chroma))
    else $error("output changed while stalled");
  a_in_accept_gap: assert property (in_valid && in_ready |=> !in_ready) else $error("input taken twice in a row");
  // Main traffic seen
  c_set_b_read: cover property (reg_read && reg_addr[7:4] == 4'hd);
  c_output_taken: cover property (out_valid && out_ready);
  c_back_pressure: cover property (in_valid && !in_ready [*4]);
endmodule

bind video_prescaler_bcs_hscale prescaler_port_checker u_checker (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready),
  .out_ready(out_ready), .out_valid(out_valid), .out_luma(out_luma), .out_chroma(out_chroma)
);

// [sim/acquisition_source.sv]
// Behavioural acquisition stage feeding luma and chroma samples to the prescaler
`timescale 1ns/1ns
module acquisition_source (
  // Clock
  input wire logic mclk,
  // Sample stream
  output logic in_valid,
  input wire logic in_ready,
  output logic [7:0] in_luma,
  output logic [7:0] in_chroma
);
  logic refused;
  // Idle at time zero
  initial begin
    in_valid = 1'b0;
    in_luma = 8'h00;
    in_chroma = 8'h00;
    refused = 1'b0;
  end
  // Sample held until taken or 300 waiting cycles pass; released lines show the inverse so stale data never matches
  task automatic send(input int n, input logic [7:0] y, input logic [7:0] c, input int gap);
    int waits;
    refused = 1'b0;
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_luma <= y;
      in_chroma <= c;
      waits = 0;
      @(posedge mclk);
      while (in_ready !== 1'b1 && waits < 300) begin
        waits++;
        @(posedge mclk);
      end
      if (in_ready !== 1'b1) begin
        refused = 1'b1;
        in_valid <= 1'b0;
        return;
      end
      // Back-to-back samples keep valid up to avoid a double drive
      if (gap > 0 || i == n - 1) begin
        in_valid <= 1'b0;
        in_luma <= ~y;
        in_chroma <= ~c;
      end
      repeat (gap) @(posedge mclk);
    end
  endtask
endmodule

// [sim/video_prescaler_bcs_hscale_tb.sv]
// Self-checking bench for the prescaler, picture controls and horizontal scaler
`timescale 1ns/1ns
module video_prescaler_bcs_hscale_tb;
  logic mclk, rst, reg_write, reg_read, set_b_select, in_valid, in_ready, out_ready, out_valid, hold;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, in_luma, in_chroma, out_luma, out_chroma, last_luma, last_chroma;
  int miscompares, comparisons, outs, cycles;
  logic [3:0] lows [7] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
  logic [7:0] defaults [7] = '{8'h00, 8'h00, 8'h80, 8'h40, 8'h40, 8'h00, 8'h04};

  video_prescaler_bcs_hscale u_dut (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .set_b_select(set_b_select), .in_valid(in_valid),
    .in_ready(in_ready), .in_luma(in_luma), .in_chroma(in_chroma), .out_ready(out_ready),
    .out_valid(out_valid), .out_luma(out_luma), .out_chroma(out_chroma)
  );
  acquisition_source u_src (
    .mclk(mclk), .in_valid(in_valid), .in_ready(in_ready), .in_luma(in_luma), .in_chroma(in_chroma)
  );

  // Pixel clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Drain side stalls one cycle in four, fully while hold is set; hang guard
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      outs = outs + 1;
      last_luma = out_luma;
      last_chroma = out_chroma;
    end
    out_ready <= !hold && cycles[1:0] != 2'h0;
    if (cycles == 40000) begin
      miscompares = miscompares + 1;
      results();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    comparisons++;
    if (seen !== expected) begin
      miscompares++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, expected);
    end
  endtask
  function automatic logic [7:0] mask(input logic [3:0] lo);
    return lo == 4'h1 ? 8'h3f : lo == 4'h9 ? 8'h1f : 8'hff;
  endfunction
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    @(posedge mclk);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic read_check(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(posedge mclk);
    check(reg_rdata, e);
  endtask
  task automatic reset_dut();
    rst <= 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask
  // Bounded wait for a quiet output side
  task automatic drain();
    int quiet;
    quiet = 0;
    for (int k = 0; k < 3000 && quiet < 24; k++) begin
      @(posedge mclk);
      quiet = (out_valid === 1'b1) ? 0 : quiet + 1;
    end
  endtask
  // Constant picture through one setting: last output and output count are checked
  task automatic stream(input logic b, input logic [7:0] filt, acc, br, ct, st, input logic [15:0] inc,
      input int n, input logic [7:0] y, c, ey, ec, input int e);
    logic [7:0] base;
    base = b ? 8'hd0 : 8'ha0;
    reset_dut();
    set_b_select <= b;
    write_reg(base | 8'h01, acc);
    write_reg(base | 8'h02, filt);
    write_reg(base | 8'h04, br);
    write_reg(base | 8'h05, ct);
    write_reg(base | 8'h06, st);
    write_reg(base | 8'h08, inc[7:0]);
    write_reg(base | 8'h09, inc[15:8]);
    outs = 0;
    u_src.send(n, y, c, 0);
    drain();
    check(last_luma, ey);
    check(last_chroma, ec);
    check({7'h00, outs >= e - 6 && outs <= e + 1}, 8'h01);
    $display("stream test done, %0d outputs", outs);
  endtask
  task automatic results();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst, reg_write, reg_read, set_b_select, out_ready, hold} = 6'h20;
    {reg_addr, reg_wdata} = 16'h0000;
    {miscompares, comparisons, outs, cycles} = '0;
    reset_dut();
    for (int i = 0; i < 7; i++) begin
      read_check({4'ha, lows[i]}, defaults[i]);
      read_check({4'hd, lows[i]}, defaults[i]);
      write_reg({4'ha, lows[i]}, {lows[i], ~lows[i]});
      write_reg({4'hd, lows[i]}, {~lows[i], lows[i]});
    end
    write_reg(8'ha3, 8'hff);
    for (int i = 0; i < 7; i++) begin
      read_check({4'ha, lows[i]}, {lows[i], ~lows[i]} & mask(lows[i]));
      read_check({4'hd, lows[i]}, {~lows[i], lows[i]} & mask(lows[i]));
    end
    read_check(8'ha3, 8'h00);
    $display("register test done");
    stream(0, 8'h00, 8'h00, 8'h80, 8'h40, 8'h40, 16'h0400, 64, 8'h64, 8'ha0, 8'h64, 8'ha0, 64);
    for (int m = 0; m < 4; m++) begin
      stream(0, {m[1:0], m[1:0], 4'h0}, 8'h00, 8'h80, 8'h40, 8'h40, 16'h0400, 64, 8'h64, 8'ha0, 8'h64, 8'ha0, 64);
    end
    stream(0, 8'h02, 8'h03, 8'h80, 8'h40, 8'h40, 16'h0400, 64, 8'h64, 8'ha0, 8'h64, 8'ha0, 16);
    stream(0, 8'h0a, 8'h03, 8'h80, 8'h40, 8'h40, 16'h0400, 64, 8'h64, 8'ha0, 8'h96, 8'hf0, 16);
    stream(0, 8'h0f, 8'hff, 8'h80, 8'h40, 8'h40, 16'h0400, 256, 8'h64, 8'ha0, 8'h62, 8'h9d, 4);
    stream(0, 8'h00, 8'h01, 8'h80, 8'h40, 8'h40, 16'h0400, 64, 8'h64, 8'ha0, 8'hc8, 8'hff, 32);
    stream(0, 8'h00, 8'h00, 8'h80, 8'h20, 8'h20, 16'h0400, 64, 8'h64, 8'ha0, 8'h32, 8'h90, 64);
    stream(0, 8'h00, 8'h00, 8'h80, 8'h7f, 8'h7f, 16'h0400, 64, 8'h64, 8'ha0, 8'hc6, 8'hbf, 64);
    stream(0, 8'h00, 8'h00, 8'hff, 8'h7f, 8'h7f, 16'h0400, 64, 8'h64, 8'h00, 8'hff, 8'h00, 64);
    stream(0, 8'h00, 8'h00, 8'h00, 8'h40, 8'h7f, 16'h0400, 64, 8'h64, 8'hff, 8'h00, 8'hff, 64);
    stream(0, 8'h00, 8'h00, 8'h80, 8'h40, 8'h40, 16'h0200, 64, 8'h64, 8'ha0, 8'h64, 8'ha0, 128);
    stream(0, 8'h00, 8'h00, 8'h80, 8'h40, 8'h40, 16'h0800, 64, 8'h64, 8'ha0, 8'h64, 8'ha0, 32);
    stream(0, 8'h00, 8'h00, 8'h80, 8'h40, 8'h40, 16'h0126, 64, 8'h64, 8'ha0, 8'h64, 8'ha0, 222);
    stream(0, 8'h00, 8'h00, 8'h80, 8'h40, 8'h40, 16'hffff, 64, 8'h64, 8'ha0, 8'h64, 8'ha0, 8);
    stream(1, 8'h00, 8'h00, 8'hc8, 8'h40, 8'h40, 16'h0400, 64, 8'h64, 8'ha0, 8'hac, 8'ha0, 64);
    read_check(8'hf0, 8'h01);
    // Far side refuses until the source gives up on the backed-up buffer, then drains; slow source
    reset_dut();
    hold <= 1'b1;
    outs = 0;
    u_src.send(40, 8'h64, 8'ha0, 1);
    check({7'h00, u_src.refused}, 8'h01);
    hold <= 1'b0;
    drain();
    check({7'h00, outs >= 9 && outs < 40}, 8'h01);
    $display("buffer test done, %0d outputs", outs);
    results();
  end
endmodule
